// ==== hdl/ppg_led_averaging_config.sv ====
/*
  ppg red led drive code, offset cancel bits, led order and pre-fifo
  averaging with output resolution report.
  assumes: a byte-wide register port fed by the i2c slave, a measurement
  enable and raw samples from the converter, all on clk.
*/
`timescale 1ns/100ps
module ppg_led_averaging_config
   import ppg_cfg_pkg::*;
#(
   parameter int WIDTH = SAMPLE_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire reg_req_t regReq,
   output logic [7:0] regRdata,
   // measurement control
   input wire logic measureEnable,
   input wire logic dualLedMode,
   input wire logic ledOrderSwap,
   input wire logic secondSlot,
   // samples
   input wire sample_t rawSample,
   output sample_t fifoSample,
   // analog side
   output logic [8:0] redLedDriveCode,
   output logic irChannelOffsetCancel,
   output logic redChannelOffsetCancel,
   output logic irLedActive,
   output logic redLedActive,
   output logic cancelActive,
   output logic [4:0] outputResolution
);
   logic [7:0] redLo_reg;
   logic redHi_reg;
   logic [7:0] offsetCancel_reg;
   logic [7:0] sampleAvg_reg;
   logic [3:0] pulseWidth_reg;
   logic measureEn_reg;
   logic [2:0] avgShift;
   logic restart;
   logic useRed;
   logic [8:0] redCode_next;

   // ************************************************************
   // register writes
   // ************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         redLo_reg <= RED_CODE_RST[7:0]; // led off after reset
         redHi_reg <= RED_CODE_RST[8];
         offsetCancel_reg <= OFFSET_CANCEL_RST;
         sampleAvg_reg <= SAMPLE_AVG_RST;
         pulseWidth_reg <= PW_CODE_130;
      end else if (regReq.write) begin
         unique case (regReq.addr)
            RED_CURR_LO_ADDR: redLo_reg <= regReq.wdata;
            RED_CURR_HI_ADDR: redHi_reg <= regReq.wdata[RED_MSB_BIT];
            OFFSET_CANCEL_ADDR: offsetCancel_reg <= regReq.wdata & OFFSET_CANCEL_MASK;
            // fixed nibble forced so a careless host cannot upset readback
            SAMPLE_AVG_ADDR: sampleAvg_reg <= {1'b0, regReq.wdata[AVG_MSB:AVG_LSB],
               AVG_FIXED_NIBBLE};
            PPG_TIMING_ADDR: pulseWidth_reg <= regReq.wdata[PW_MSB:PW_LSB];
            default: ;
         endcase
      end
   end

   // ************************************************************
   // register reads
   // ************************************************************
   always_comb begin
      regRdata = ZERO_BYTE;
      if (regReq.read) begin
         unique case (regReq.addr)
            RED_CURR_LO_ADDR: regRdata = redLo_reg;
            RED_CURR_HI_ADDR: regRdata = {7'h00, redHi_reg};
            OFFSET_CANCEL_ADDR: regRdata = offsetCancel_reg;
            SAMPLE_AVG_ADDR: regRdata = sampleAvg_reg;
            default: regRdata = ZERO_BYTE;
         endcase
      end
   end

   // ************************************************************
   // led drive and cancellation
   // ************************************************************
   // code is passed on linearly; the driver dac scales it to ~0.24mA/step
   assign redCode_next = {redHi_reg, redLo_reg};
   assign useRed = ledOrderSwap ^ (dualLedMode & secondSlot);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         redLedDriveCode <= RED_CODE_RST;
         irChannelOffsetCancel <= 1'b0;
         redChannelOffsetCancel <= 1'b0;
         irLedActive <= 1'b0;
         redLedActive <= 1'b0;
         cancelActive <= 1'b0;
      end else begin
         redLedDriveCode <= redCode_next;
         irChannelOffsetCancel <= offsetCancel_reg[IR_CANCEL_BIT];
         redChannelOffsetCancel <= offsetCancel_reg[RED_CANCEL_BIT];
         irLedActive <= measureEnable && !useRed;
         redLedActive <= measureEnable && useRed;
         // cancel applies to whichever led integrates now
         cancelActive <= measureEnable && (useRed ? offsetCancel_reg[RED_CANCEL_BIT]
            : offsetCancel_reg[IR_CANCEL_BIT]);
      end
   end

   // ************************************************************
   // averaging and resolution
   // ************************************************************
   // codes above 100 saturate at 32 samples
   assign avgShift = (sampleAvg_reg[AVG_MSB:AVG_LSB] > AVG_CODE_MAX) ? AVG_CODE_MAX
      : sampleAvg_reg[AVG_MSB:AVG_LSB];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         measureEn_reg <= 1'b0;
      end else begin
         measureEn_reg <= measureEnable;
      end
   end
   assign restart = measureEnable && !measureEn_reg;

   sample_averager #(
      .WIDTH(WIDTH),
      .MAX_SHIFT(5)
   ) averager (
      .clk(clk),
      .resetn(resetn),
      .restart(restart),
      .shift(avgShift),
      .sampleIn(rawSample),
      .sampleOut(fifoSample)
   );

   // short pulses gain a bit per doubling up to 18
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outputResolution <= RES_16_W;
      end else if (pulseWidth_reg != PW_CODE_130) begin
         outputResolution <= RES_18_W;
      end else begin
         unique case (avgShift)
            3'h0: outputResolution <= RES_16_W;
            3'h1: outputResolution <= RES_17_W;
            default: outputResolution <= RES_18_W;
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   red_code_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      regReq.write && regReq.addr == RED_CURR_HI_ADDR |-> ##2
      redLedDriveCode[8] == $past(regReq.wdata[RED_MSB_BIT], 2))
      else $error("red msb lost");
   red_low_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      regReq.write && regReq.addr == RED_CURR_LO_ADDR |-> ##2
      redLedDriveCode[7:0] == $past(regReq.wdata, 2))
      else $error("red low byte lost");
   cancel_map_a: assert property (@(posedge clk) disable iff (!resetn)
      ##1 irChannelOffsetCancel == $past(offsetCancel_reg[IR_CANCEL_BIT]))
      else $error("ir cancel wrong");
   red_cancel_a: assert property (@(posedge clk) disable iff (!resetn)
      redChannelOffsetCancel == $past(offsetCancel_reg[RED_CANCEL_BIT]))
      else $error("red cancel wrong");
   active_cancel_a: assert property (@(posedge clk) disable iff (!resetn)
      cancelActive == ((redLedActive && redChannelOffsetCancel)
      || (irLedActive && irChannelOffsetCancel))) else $error("cancel not on active led");
   avg_fixed_a: assert property (@(posedge clk) disable iff (!resetn)
      sampleAvg_reg[3:0] == AVG_FIXED_NIBBLE && !sampleAvg_reg[7]) else $error("avg fixed");
   avg_sat_a: assert property (@(posedge clk) disable iff (!resetn)
      avgShift <= AVG_CODE_MAX) else $error("avg shift too big");
   avg_code_sat_a: assert property (@(posedge clk) disable iff (!resetn)
      sampleAvg_reg[AVG_MSB:AVG_LSB] >= AVG_CODE_MAX |-> avgShift == AVG_CODE_MAX)
      else $error("avg code not saturated");
   led_order_a: assert property (@(posedge clk) disable iff (!resetn)
      measureEnable && !ledOrderSwap && !dualLedMode |=> irLedActive && !redLedActive)
      else $error("led order");
   red_first_a: assert property (@(posedge clk) disable iff (!resetn)
      measureEnable && ledOrderSwap && !dualLedMode |=> redLedActive && !irLedActive)
      else $error("swap not applied");
   dual_second_a: assert property (@(posedge clk) disable iff (!resetn)
      measureEnable && dualLedMode && secondSlot && !ledOrderSwap |=> redLedActive)
      else $error("second slot not red");
   res_long_a: assert property (@(posedge clk) disable iff (!resetn)
      pulseWidth_reg != PW_CODE_130 |=> outputResolution == RES_18_W) else $error("res");
   res_short_a: assert property (@(posedge clk) disable iff (!resetn)
      pulseWidth_reg == PW_CODE_130 && avgShift == 3'h0 |=> outputResolution == RES_16_W)
      else $error("short pulse resolution");
   restart_drop_a: assert property (@(posedge clk) disable iff (!resetn)
      restart |=> !fifoSample.valid)
      else $error("sample kept across restart");
   no_avg_pass_a: assert property (@(posedge clk) disable iff (!resetn)
      rawSample.valid && avgShift == 3'h0 && !restart |=> fifoSample.valid)
      else $error("unaveraged sample dropped");
   off_reset_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> redLedDriveCode == RED_CODE_RST) else $error("led not off");
   cov_avg32_c: cover property (@(posedge clk) avgShift == AVG_CODE_MAX && fifoSample.valid);
   cov_dual_c: cover property (@(posedge clk) dualLedMode && redLedActive);
   cov_res17_c: cover property (@(posedge clk) outputResolution == RES_17_W);
   cov_swap_c: cover property (@(posedge clk) ledOrderSwap && !dualLedMode && redLedActive);
   cov_restart_c: cover property (@(posedge clk) restart && rawSample.valid);
endmodule : ppg_led_averaging_config

// ==== hdl/ppg_cfg_pkg.sv ====
/*
  constants, register map and carrier types for the ppg led drive and
  sample averaging block.
  assumes: an i2c slave elsewhere turns bus traffic into byte writes/reads.
*/
package ppg_cfg_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] RED_CURR_LO_ADDR = 8'h32;
   localparam logic [7:0] RED_CURR_HI_ADDR = 8'h33;
   localparam logic [7:0] OFFSET_CANCEL_ADDR = 8'h34;
   localparam logic [7:0] SAMPLE_AVG_ADDR = 8'h35;
   localparam logic [7:0] PPG_TIMING_ADDR = 8'h36;
   localparam logic [7:0] OFFSET_CANCEL_RST = 8'h00;
   localparam logic [7:0] SAMPLE_AVG_RST = 8'h0a;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [8:0] RED_CODE_RST = 9'h000;
   localparam logic [3:0] AVG_FIXED_NIBBLE = 4'ha;
   localparam logic [7:0] OFFSET_CANCEL_MASK = 8'h05;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int IR_CANCEL_BIT = 2;
   localparam int RED_CANCEL_BIT = 0;
   localparam int AVG_LSB = 4;
   localparam int AVG_MSB = 6;
   localparam int RED_MSB_BIT = 0;
   localparam int PW_LSB = 4;
   localparam int PW_MSB = 7;
   // ************************************************************
   // codes and resolution
   // ************************************************************
   localparam logic [2:0] AVG_CODE_MAX = 3'h5;
   localparam logic [3:0] PW_CODE_130 = 4'h3;
   localparam int RES_16 = 16;
   localparam int RES_17 = 17;
   localparam int RES_18 = 18;
   localparam logic [4:0] RES_16_W = 5'h10;
   localparam logic [4:0] RES_17_W = 5'h11;
   localparam logic [4:0] RES_18_W = 5'h12;
   localparam int SAMPLE_W = 18;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] data;
   } sample_t;
endpackage : ppg_cfg_pkg

// ==== hdl/sample_averager.sv ====
/*
  averages 2**shift consecutive samples, one result per group.
  assumes: samples arrive as one-cycle valid pulses on the system clock.
*/
`timescale 1ns/100ps
module sample_averager
   import ppg_cfg_pkg::*;
#(
   parameter int WIDTH = SAMPLE_W,
   parameter int MAX_SHIFT = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic restart,
   input wire logic [2:0] shift,
   // samples
   input wire sample_t sampleIn,
   output sample_t sampleOut
);
   localparam int ACC_W = WIDTH + MAX_SHIFT;
   logic [ACC_W-1:0] acc_reg;
   logic [MAX_SHIFT:0] count_reg;
   logic [ACC_W-1:0] sum;
   logic [MAX_SHIFT:0] groupLen;
   logic lastOne;

   assign sum = acc_reg + ACC_W'(sampleIn.data);
   assign groupLen = (MAX_SHIFT+1)'(1) << shift;
   // >= so a group size shrunk mid-group closes the group at once
   assign lastOne = (count_reg + (MAX_SHIFT+1)'(1)) >= groupLen;

   // mean is the sum shifted down; truncation toward zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_reg <= '0;
         count_reg <= '0;
      end else if (restart) begin
         acc_reg <= '0; // fresh group on each new sequence
         count_reg <= '0;
      end else if (sampleIn.valid) begin
         if (lastOne) begin
            acc_reg <= '0;
            count_reg <= '0;
         end else begin
            acc_reg <= sum;
            count_reg <= count_reg + (MAX_SHIFT+1)'(1);
         end
      end
   end

   // one word per group lowers the output rate by the group size
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sampleOut <= '0;
      end else begin
         sampleOut.valid <= sampleIn.valid && lastOne && !restart;
         if (sampleIn.valid && lastOne) begin
            sampleOut.data <= WIDTH'(sum >> shift);
         end
      end
   end
endmodule : sample_averager

// ==== test/host_model.sv ====
/*
  host side of the register port: byte writes and reads, fixed bits and
  legal timing pairs applied before anything reaches the block.
  assumes: block samples regReq on posedge clk, regRdata combinational.
*/
`timescale 1ns/100ps
module host_model
   import ppg_cfg_pkg::*;
(
   // clock
   input wire logic clk,
   // register port
   output reg_req_t regReq,
   input wire logic [7:0] regRdata
);
   initial regReq = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq.addr = a;
      if (a == SAMPLE_AVG_ADDR) begin
         regReq.wdata = {1'b0, d[AVG_MSB:AVG_LSB], AVG_FIXED_NIBBLE};
      end else begin
         regReq.wdata = (a == OFFSET_CANCEL_ADDR) ? (d & OFFSET_CANCEL_MASK) : d;
      end
      regReq.write = 1'b1;
      @(negedge clk);
      regReq.write = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regReq.addr = a;
      regReq.read = 1'b1;
      @(posedge clk);
      d = regRdata;
      @(negedge clk);
      regReq.read = 1'b0;
   endtask : rd

   // shortest legal period only; slower ones add run time for nothing
   task automatic wr_timing(input logic [3:0] pw, input logic dual);
      logic [3:0] per;
      case (pw)
         4'h3: per = dual ? 4'h1 : 4'h0;
         4'h4: per = dual ? 4'h2 : 4'h1;
         4'h5: per = dual ? 4'h4 : 4'h2;
         default: per = dual ? 4'h5 : 4'h4;
      endcase
      wr(PPG_TIMING_ADDR, {pw, per});
   endtask : wr_timing
endmodule : host_model

// ==== test/ppg_led_averaging_config_tb_top.sv ====
/*
  self-checking bench: drive code, cancel bits, led order, averaging.
  assumes: host_model drives the register port; clk 25MHz.
*/
`timescale 1ns/100ps
module ppg_led_averaging_config_tb_top;
   import ppg_cfg_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   reg_req_t regReq;
   logic [7:0] regRdata;
   logic measureEnable = 1'b0;
   logic dualLedMode = 1'b0;
   logic ledOrderSwap = 1'b0;
   logic secondSlot = 1'b0;
   sample_t rawSample = '0;
   sample_t fifoSample;
   logic [8:0] redLedDriveCode;
   logic irCan, redCan, irAct, redAct, canAct;
   logic [4:0] outputResolution;
   int nFail = 0;
   int checkCount = 0;
   int nOut = 0;

   always #20 clk = ~clk;

   // counts each result pulse at the edge that ends it
   always @(posedge clk) begin
      if (fifoSample.valid === 1'b1) begin
         nOut++;
      end
   end

   ppg_led_averaging_config i_dut (.clk(clk), .resetn(resetn), .regReq(regReq),
      .regRdata(regRdata), .measureEnable(measureEnable), .dualLedMode(dualLedMode),
      .ledOrderSwap(ledOrderSwap), .secondSlot(secondSlot), .rawSample(rawSample),
      .fifoSample(fifoSample), .redLedDriveCode(redLedDriveCode),
      .irChannelOffsetCancel(irCan), .redChannelOffsetCancel(redCan),
      .irLedActive(irAct), .redLedActive(redAct), .cancelActive(canAct),
      .outputResolution(outputResolution));
   host_model i_host (.clk(clk), .regReq(regReq), .regRdata(regRdata));

   task automatic chk(input logic [17:0] g, input logic [17:0] e);
      checkCount++;
      if (g !== e) begin
         nFail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic finish_test();
      if (nFail == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   function automatic logic [4:0] exp_res(input logic [3:0] pw, input logic [2:0] a);
      if (pw != PW_CODE_130) return RES_18_W;
      return (a == 3'h0) ? RES_16_W : ((a == 3'h1) ? RES_17_W : RES_18_W);
   endfunction : exp_res

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [7:0] d;
      logic [8:0] code;
      logic [23:0] sum;
      logic [3:0] pw;
      logic rf;
      int n;
      int w;
      int base;
      void'($urandom(32'h6d1daac6));
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      chk(redLedDriveCode, 18'h0);
      chk(outputResolution, RES_16_W);
      i_host.rd(OFFSET_CANCEL_ADDR, d);
      chk(d, OFFSET_CANCEL_RST);
      i_host.rd(SAMPLE_AVG_ADDR, d);
      chk(d, SAMPLE_AVG_RST);
      i_host.rd(8'h40, d);
      chk(d, ZERO_BYTE);
      for (int i = 0; i < 6; i++) begin
         code = (i == 0) ? 9'h1ff : ((i == 1) ? 9'h000 : 9'($urandom));
         i_host.wr(RED_CURR_LO_ADDR, code[7:0]);
         i_host.wr(RED_CURR_HI_ADDR, {7'h0, code[8]});
         @(negedge clk);
         chk(redLedDriveCode, code);
         i_host.rd(RED_CURR_LO_ADDR, d);
         chk(d, code[7:0]);
         i_host.rd(RED_CURR_HI_ADDR, d);
         chk(d, {7'h00, code[8]});
      end
      for (int i = 0; i < 4; i++) begin
         i_host.wr(OFFSET_CANCEL_ADDR, {5'h0, i[1], 1'b0, i[0]});
         @(negedge clk);
         chk(irCan, i[1]);
         chk(redCan, i[0]);
         i_host.rd(OFFSET_CANCEL_ADDR, d);
         chk(d, {5'h0, i[1], 1'b0, i[0]});
      end
      measureEnable = 1'b1;
      // first half with ir cancel only, second half with red cancel only
      for (int j = 0; j < 16; j++) begin
         if (j[2:0] == 3'h0) begin
            i_host.wr(OFFSET_CANCEL_ADDR, j[3] ? 8'h01 : 8'h04);
         end
         {dualLedMode, ledOrderSwap, secondSlot} = j[2:0];
         repeat (2) @(negedge clk);
         rf = ledOrderSwap ^ (dualLedMode & secondSlot);
         chk(redAct, rf);
         chk(irAct, !rf);
         chk(canAct, rf ? j[3] : !j[3]);
      end
      for (int a = 0; a < 8; a++) begin
         pw = 4'h3 + 4'($urandom_range(3));
         dualLedMode = a[0];
         i_host.wr_timing((a < 3) ? 4'h3 : pw, dualLedMode);
         i_host.wr(SAMPLE_AVG_ADDR, {1'b0, 3'(a), 4'ha});
         i_host.rd(SAMPLE_AVG_ADDR, d);
         chk(d, {1'b0, 3'(a), AVG_FIXED_NIBBLE});
         base = nOut;
         measureEnable = 1'b0;
         rawSample = {1'b1, 18'($urandom)};
         @(negedge clk);
         // lands in the restart cycle, so it must not reach the sum
         rawSample = {1'b1, 18'($urandom)};
         measureEnable = 1'b1;
         @(negedge clk);
         n = (a >= 5) ? 32 : (1 << a);
         sum = '0;
         for (int k = 0; k < n; k++) begin
            rawSample = {1'b1, 18'($urandom)};
            sum += 24'(rawSample.data);
            @(negedge clk);
         end
         rawSample.valid = 1'b0;
         for (w = 0; w < 4 && fifoSample.valid !== 1'b1; w++) begin
            @(posedge clk);
            #1;
         end
         if (w == 4) begin
            nFail++;
            break;
         end
         chk(fifoSample.data, 18'(sum >> ((a >= 5) ? 5 : a)));
         chk(outputResolution, exp_res((a < 3) ? 4'h3 : pw, 3'(a)));
         @(negedge clk);
         // a group of one before the restart gives a word of its own
         chk(18'(nOut - base), (a == 0) ? 18'h2 : 18'h1);
      end
      // reset in mid-run: drive code, resolution, averaging and red low byte back to reset values
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      chk(redLedDriveCode, 18'h0);
      chk(outputResolution, RES_16_W);
      i_host.rd(SAMPLE_AVG_ADDR, d);
      chk(d, SAMPLE_AVG_RST);
      i_host.rd(RED_CURR_LO_ADDR, d);
      chk(d, ZERO_BYTE);
      finish_test();
   end
endmodule : ppg_led_averaging_config_tb_top
